/* File: rtl/rfo_map.svh */
`ifndef RFO_MAP_SVH
`define RFO_MAP_SVH

// Register indices; byte address is four times the index.
`define RFO_IDX_BF        8'h07
`define RFO_IDX_PT        8'h08
`define RFO_IDX_SM        8'h09
`define RFO_IDX_AUX       8'h0A
`define RFO_IDX_CTL       8'h0B
`define RFO_IDX_STAT      8'h0C

// Writable bit masks; reserved bits are cleared.
`define RFO_MASK_BF       8'hF3
`define RFO_MASK_PT       8'hFD
`define RFO_MASK_SM       8'h7F
`define RFO_MASK_AUX      8'hBF
`define RFO_MASK_CTL      8'h0F
`define RFO_RST_REG       8'h00

// Field positions.
`define RFO_BF_TR1_LSB    6
`define RFO_BF_NOSOF      5
`define RFO_BF_NOEOF      4
`define RFO_BF_PRE_LSB    0
`define RFO_PT_FDEL_LSB   4
`define RFO_PT_AP2P_OFF   3
`define RFO_PT_POLL_OFF   2
`define RFO_PT_ACOLL_OFF  0
`define RFO_SM_SCF_LSB    5
`define RFO_SM_SCP_LSB    3
`define RFO_SM_STX_LSB    0
`define RFO_AUX_NOCRC     7
`define RFO_AUX_ID_LSB    4
`define RFO_AUX_PHCLK     3
`define RFO_AUX_DISCORR   2
`define RFO_AUX_N_LSB     0

// Timing figures, all in carrier periods, then the AXI response codes.
`define RFO_TR1_SLOW      10'd640
`define RFO_TR1_FAST_SLOW 10'd512
`define RFO_TR1_FAST      10'd256
`define RFO_PRE_BASE      7'd48
`define RFO_PRE_STEP      7'd16
`define RFO_AXI_OKAY      2'b00
`define RFO_AXI_SLVERR    2'b10

`endif

/* File: rtl/rfo_pkg.sv */
package rfo_pkg;

    typedef enum logic [1:0] {
        RFO_PROT_A,
        RFO_PROT_B,
        RFO_PROT_F,
        RFO_PROT_STREAM
    } rfo_prot_t;

    typedef enum logic [1:0] {
        RFO_SM_SUBC,
        RFO_SM_BPSK,
        RFO_SM_OFF
    } rfo_smode_t;

    typedef struct packed {
        logic [9:0] tr1_min_fc;
        logic       accept_no_sof;
        logic       accept_no_eof;
        logic [6:0] preamble_len;
        logic       crc_check_en;
        logic       pulse_rx;
        logic       phase_clk_90;
        logic [1:0] field_on_n;
        logic [1:0] id_size;
    } rfo_rx_cfg_t;

    typedef struct packed {
        logic [3:0] fdt_comp;
        logic       ap2p_recog_en;
        logic       auto_anticoll_en;
        logic       auto_poll_en;
        logic       fifo_only;
    } rfo_pt_cfg_t;

    typedef struct packed {
        logic [3:0] subc_div_log2;
        logic [3:0] pulses;
        logic [3:0] tx_div_log2;
        logic       cfg_error;
    } rfo_sm_cfg_t;

endpackage

/* File: rtl/rfo_stream_timer.sv */
`timescale 1ns/1ps
`include "rfo_map.svh"

// Produces the stream-mode sub-carrier and modulator period strobes.
module rfo_stream_timer
    import rfo_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Setup
    input  wire logic        run,
    input  wire rfo_sm_cfg_t cfg,
    // Strobes
    output logic             subc_tick,
    output logic             tx_tick,
    output logic             report_tick
);

    logic [7:0] div_ff;
    logic [3:0] pulse_ff;
    logic [7:0] subc_mask;
    logic [7:0] tx_mask;

    function automatic logic [7:0] div_mask(input logic [3:0] lg);
        div_mask = 8'(({8'h00, 8'hFF} >> (4'd8 - lg)) & 16'h00FF);
    endfunction

    assign subc_mask   = div_mask(cfg.subc_div_log2);
    assign tx_mask     = div_mask(cfg.tx_div_log2);
    assign subc_tick   = run && ((div_ff & subc_mask) == 8'h00);
    assign tx_tick     = run && ((div_ff & tx_mask) == 8'h00);
    assign report_tick = subc_tick && (pulse_ff == 4'h0);

    always_ff @(posedge clk)
    begin
        if (!rst_n || !run)
        begin
            div_ff   <= 8'h00;
            pulse_ff <= 4'h0;
        end
        else
        begin
            div_ff <= div_ff + 8'h01;
            if (subc_tick)
                pulse_ff <= (pulse_ff == cfg.pulses - 4'h1) ? 4'h0
                                                            : pulse_ff + 4'h1;
        end
    end

endmodule

/* File: rtl/rfo_fdt_timer.sv */
`timescale 1ns/1ps
`include "rfo_map.svh"

// Counts the frame delay in carrier periods, less the compensation.
module rfo_fdt_timer
    import rfo_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        start,
    input  wire logic [11:0] nominal,
    input  wire logic [3:0]  comp,
    // Status
    output logic             busy,
    output logic             done
);

    logic [11:0] cnt_ff;
    logic        busy_ff;
    logic [11:0] target;

    // A compensation larger than the delay saturates to one cycle.
    assign target = (nominal > {8'h00, comp}) ? nominal - {8'h00, comp}
                                               : 12'h001;
    assign busy   = busy_ff;
    assign done   = busy_ff && (cnt_ff == 12'h001);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_ff  <= 12'h000;
            busy_ff <= 1'b0;
        end
        else if (start)
        begin
            cnt_ff  <= target;
            busy_ff <= 1'b1;
        end
        else if (busy_ff)
        begin
            cnt_ff  <= cnt_ff - 12'h001;
            busy_ff <= (cnt_ff != 12'h001);
        end
    end

endmodule

/* File: rtl/rfo_framing.sv */
// Operation
// - Turnaround field sets minimum card turnaround time
// - No-SOF bit accepts frames without start
// - No-EOF bit accepted only in coherent reception
// - Preamble field selects 48, 64, 80, 96
// - Compensation shortens frame delay by carrier periods
// - Active peer recognition off when bit set
// - Bits stop automatic anticollision and poll reply
// - Automatic replies off means FIFO-only traffic
// - Sub-carrier frequency field per stream mode
// - Pulse count 1,2,4,8; small counts BPSK only
// - Modulator period field; top-bit codes reserved
// - CRC bypass bit skips receive CRC check
// - CRC skipped for REQ/WUP and anticollision; code skips it for type A only
// - Phase clock bit selects 0 or 90 degrees
// - Correlator disable selects pulse reception where valid
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "rfo_map.svh"

module rfo_framing
    import rfo_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // AXI4-Lite write address and data
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    // AXI4-Lite write response
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    // Framing context from the protocol engine
    input  wire rfo_prot_t   PROT,
    input  wire logic        COHERENT_RX,
    input  wire logic        REQ_WUP_SENT,
    input  wire logic        ANTICOLL_FRAME,
    input  wire logic        PASSIVE_TARGET,
    input  wire rfo_smode_t  STREAM_MODE,
    input  wire logic        FDT_START,
    input  wire logic [11:0] FDT_NOMINAL,
    // Applied configuration
    output rfo_rx_cfg_t      RX_CFG,
    output rfo_pt_cfg_t      PT_CFG,
    output rfo_sm_cfg_t      SM_CFG,
    // Strobes
    output logic             FDT_DONE,
    output logic             SUBC_TICK,
    output logic             TX_TICK,
    output logic             REPORT_TICK
);

    logic [7:0]  bf_ff;
    logic [7:0]  pt_ff;
    logic [7:0]  sm_ff;
    logic [7:0]  aux_ff;
    logic [7:0]  ctl_ff;
    logic        aw_ff;
    logic        w_ff;
    logic [31:0] awaddr_ff;
    logic [7:0]  wdata_ff;
    logic        wlane_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    rfo_rx_cfg_t rx_ff;
    rfo_pt_cfg_t pt_cfg_ff;
    rfo_sm_cfg_t sm_cfg_ff;

    // Register index decode, shared by read and write paths.
    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[31:10] != 22'h0 || a[1:0] != 2'b00)
            reg_sel = 3'd0;
        else if (idx == `RFO_IDX_BF)
            reg_sel = 3'd1;
        else if (idx == `RFO_IDX_PT)
            reg_sel = 3'd2;
        else if (idx == `RFO_IDX_SM)
            reg_sel = 3'd3;
        else if (idx == `RFO_IDX_AUX)
            reg_sel = 3'd4;
        else if (idx == `RFO_IDX_CTL)
            reg_sel = 3'd5;
        else if (idx == `RFO_IDX_STAT)
            reg_sel = 3'd6;
        else
            reg_sel = 3'd0;
    endfunction

    // Write channel: address and data are latched independently.
    // A response still waiting blocks the next write, so a slow master
    // only stalls itself.
    wire       do_write = aw_ff && w_ff && !bvalid_ff;
    wire [2:0] wsel     = reg_sel(awaddr_ff);
    wire       wr_ok    = (wsel != 3'd0) && (wsel != 3'd6);
    wire       wr_en    = do_write && wr_ok && wlane_ff;

    assign AWREADY = !aw_ff;
    assign WREADY  = !w_ff;
    assign BVALID  = bvalid_ff;
    assign BRESP   = bresp_ff;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= 32'h00000000;
            wdata_ff  <= 8'h00;
            wlane_ff  <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RFO_AXI_OKAY;
        end
        else
        begin
            if (AWVALID && !aw_ff)
            begin
                aw_ff     <= 1'b1;
                awaddr_ff <= AWADDR;
            end
            if (WVALID && !w_ff)
            begin
                w_ff     <= 1'b1;
                wdata_ff <= WDATA[7:0];
                wlane_ff <= WSTRB[0];
            end
            if (do_write)
            begin
                aw_ff     <= 1'b0;
                w_ff      <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_ok ? `RFO_AXI_OKAY : `RFO_AXI_SLVERR;
            end
            else if (bvalid_ff && BREADY)
                bvalid_ff <= 1'b0;
        end
    end

    // Reserved bits are masked on write so they always read zero.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            bf_ff  <= `RFO_RST_REG;
            pt_ff  <= `RFO_RST_REG;
            sm_ff  <= `RFO_RST_REG;
            aux_ff <= `RFO_RST_REG;
            ctl_ff <= `RFO_RST_REG;
        end
        else if (wr_en)
        begin
            case (wsel)
                3'd1: bf_ff  <= wdata_ff & `RFO_MASK_BF;
                3'd2: pt_ff  <= wdata_ff & `RFO_MASK_PT;
                3'd3: sm_ff  <= wdata_ff & `RFO_MASK_SM;
                3'd4: aux_ff <= wdata_ff & `RFO_MASK_AUX;
                3'd5: ctl_ff <= wdata_ff & `RFO_MASK_CTL;
                default: ;
            endcase
        end
    end

    // Field extraction.
    wire [1:0] min_turnaround = bf_ff[`RFO_BF_TR1_LSB +: 2];
    wire [1:0] preamble_sel   = bf_ff[`RFO_BF_PRE_LSB +: 2];
    wire [3:0] fdel           = pt_ff[`RFO_PT_FDEL_LSB +: 4];
    wire [1:0] scf            = sm_ff[`RFO_SM_SCF_LSB +: 2];
    wire [1:0] scp            = sm_ff[`RFO_SM_SCP_LSB +: 2];
    wire [2:0] stx            = sm_ff[`RFO_SM_STX_LSB +: 3];
    wire       slow_rate      = (ctl_ff[1:0] == 2'b00);

    // The turnaround time is held in carrier periods; fs is fc/8.
    // Unused codes give zero so that they never hold off a reply.
    wire [9:0] tr1_fc = (min_turnaround == 2'b00) ? `RFO_TR1_SLOW :
                        (min_turnaround == 2'b01) ?
                            (slow_rate ? `RFO_TR1_FAST_SLOW
                                       : `RFO_TR1_FAST) :
                        10'h000;

    wire [6:0] pre_len = `RFO_PRE_BASE +
                         7'(`RFO_PRE_STEP * {5'h00, preamble_sel});

    wire crc_en = !aux_ff[`RFO_AUX_NOCRC] &&
                  !(PROT == RFO_PROT_A && (REQ_WUP_SENT || ANTICOLL_FRAME));

    // Pulse reception is not defined for type A, which stays on the
    // correlator. Only one stream setting has a correlator; the others
    // can only use pulse reception, whatever the disable bit says.
    wire pulse_ok   = (PROT == RFO_PROT_B && COHERENT_RX) ||
                      PROT == RFO_PROT_F || PROT == RFO_PROT_STREAM;
    wire corr_none  = (PROT == RFO_PROT_STREAM) &&
                      !(scf == 2'b01 && scp == 2'b11);
    wire pulse_sel  = (aux_ff[`RFO_AUX_DISCORR] && pulse_ok) ||
                      corr_none;
    wire sm_running = (PROT == RFO_PROT_STREAM) &&
                      (STREAM_MODE != RFO_SM_OFF);

    wire auto_ac_en = !pt_ff[`RFO_PT_ACOLL_OFF];
    wire auto_pl_en = !pt_ff[`RFO_PT_POLL_OFF];

    // Stream timing decode, with a flag for reserved combinations.
    wire       bpsk     = (STREAM_MODE == RFO_SM_BPSK);
    wire [3:0] subc_lg  = bpsk ? 4'd4 : 4'(4'd6 - {2'b00, scf});
    wire [3:0] pulses   = 4'(4'h1 << scp);
    wire [3:0] tx_lg    = 4'(4'd7 - {2'b00, stx[1:0]});
    wire       sm_err   = (bpsk && scf != 2'b00) ||
                          (!bpsk && !scp[1]) ||
                          stx[2];

    // Applied settings are registered so every consumer sees a change
    // on the same edge, one cycle after the register write.
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            rx_ff <= '0;
        else
        begin
            rx_ff.tr1_min_fc    <= tr1_fc;
            rx_ff.accept_no_sof <= bf_ff[`RFO_BF_NOSOF];
            rx_ff.accept_no_eof <= bf_ff[`RFO_BF_NOEOF] && COHERENT_RX;
            rx_ff.preamble_len  <= pre_len;
            rx_ff.crc_check_en  <= crc_en;
            rx_ff.pulse_rx      <= pulse_sel;
            rx_ff.phase_clk_90  <= aux_ff[`RFO_AUX_PHCLK];
            rx_ff.field_on_n    <= aux_ff[`RFO_AUX_N_LSB +: 2];
            rx_ff.id_size       <= aux_ff[`RFO_AUX_ID_LSB +: 2];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            pt_cfg_ff <= '0;
        else
        begin
            pt_cfg_ff.fdt_comp  <= fdel;
            pt_cfg_ff.ap2p_recog_en <= !pt_ff[`RFO_PT_AP2P_OFF];
            pt_cfg_ff.auto_anticoll_en <= PASSIVE_TARGET && auto_ac_en;
            pt_cfg_ff.auto_poll_en <= PASSIVE_TARGET && auto_pl_en;
            pt_cfg_ff.fifo_only <= PASSIVE_TARGET &&
                                   !(auto_ac_en && auto_pl_en);
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            sm_cfg_ff <= '0;
        else
        begin
            sm_cfg_ff.subc_div_log2 <= subc_lg;
            sm_cfg_ff.pulses        <= pulses;
            sm_cfg_ff.tx_div_log2   <= tx_lg;
            sm_cfg_ff.cfg_error     <= sm_running && sm_err;
        end
    end

    assign RX_CFG = rx_ff;
    assign PT_CFG = pt_cfg_ff;
    assign SM_CFG = sm_cfg_ff;

    // The frame delay only runs for type A card emulation.
    rfo_fdt_timer u_fdt
    (
        .clk     (CLK),
        .rst_n   (RST_N),
        .start   (FDT_START && PASSIVE_TARGET && PROT == RFO_PROT_A),
        .nominal (FDT_NOMINAL),
        .comp    (pt_cfg_ff.fdt_comp),
        .busy    (),
        .done    (FDT_DONE)
    );

    // Reserved timing codes stop the strobes rather than guess a rate.
    rfo_stream_timer u_stream
    (
        .clk         (CLK),
        .rst_n       (RST_N),
        .run         (sm_running && !sm_cfg_ff.cfg_error),
        .cfg         (sm_cfg_ff),
        .subc_tick   (SUBC_TICK),
        .tx_tick     (TX_TICK),
        .report_tick (REPORT_TICK)
    );

    // Read channel. The address is decoded straight from the bus, so
    // the data is ready one cycle after the request is taken; a waiting
    // answer holds off the next request.
    wire [2:0] rsel = reg_sel(ARADDR);
    wire [7:0] stat = {4'h0, sm_cfg_ff.cfg_error, rx_ff.crc_check_en,
                       rx_ff.pulse_rx, pt_cfg_ff.fifo_only};
    wire [7:0] rmux = (rsel == 3'd1) ? bf_ff :
                      (rsel == 3'd2) ? pt_ff :
                      (rsel == 3'd3) ? sm_ff :
                      (rsel == 3'd4) ? aux_ff :
                      (rsel == 3'd5) ? ctl_ff :
                      (rsel == 3'd6) ? stat : 8'h00;

    assign ARREADY = !rvalid_ff;
    assign RVALID  = rvalid_ff;
    assign RDATA   = rdata_ff;
    assign RRESP   = rresp_ff;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `RFO_AXI_OKAY;
        end
        else if (ARVALID && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= {24'h000000, rmux};
            rresp_ff  <= (rsel != 3'd0) ? `RFO_AXI_OKAY : `RFO_AXI_SLVERR;
        end
        else if (rvalid_ff && RREADY)
            rvalid_ff <= 1'b0;
    end

endmodule

/* File: verification/rfo_framing_chk.sv */
`timescale 1ns/1ps

module rfo_framing_chk
    import rfo_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // Bus handshakes
    input wire logic        BVALID,
    input wire logic        BREADY,
    input wire logic        ARVALID,
    input wire logic        ARREADY,
    input wire logic        RVALID,
    input wire logic        RREADY,
    input wire logic [31:0] RDATA,
    // Context and configuration
    input wire rfo_prot_t   PROT,
    input wire logic        COHERENT_RX,
    input wire logic        REQ_WUP_SENT,
    input wire logic        ANTICOLL_FRAME,
    input wire rfo_rx_cfg_t RX_CFG,
    input wire rfo_pt_cfg_t PT_CFG
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_rd_taken;
        ARVALID && ARREADY;
    endsequence
    sequence s_rd_done;
        RVALID && RREADY;
    endsequence
    sequence s_wr_done;
        BVALID && BREADY;
    endsequence

    a_r_follows: assert property (s_rd_taken |=> RVALID)
        else $error("read answer missing");
    a_r_once: assert property (s_rd_done |=> !RVALID)
        else $error("read answer repeated");
    a_b_once: assert property (s_wr_done |=> !BVALID)
        else $error("write answer repeated");
    a_rd_upper:
        assert property (RVALID |-> RDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_tr1_codes:
        assert property (RX_CFG.tr1_min_fc inside
            {10'h000, 10'h100, 10'h200, 10'h280})
        else $error("turnaround value off the table");
    // The config holds zero through reset, so the first edge is skipped.
    a_preamble_set:
        assert property ($past(RST_N) |-> RX_CFG.preamble_len inside
            {7'h30, 7'h40, 7'h50, 7'h60})
        else $error("preamble length off the table");
    a_eof_coherent:
        assert property (RX_CFG.accept_no_eof |-> $past(COHERENT_RX))
        else $error("missing end accepted outside coherent mode");
    a_crc_auto:
        assert property (PROT == RFO_PROT_A &&
            (REQ_WUP_SENT || ANTICOLL_FRAME) |=> !RX_CFG.crc_check_en)
        else $error("check not skipped");
    a_pulse_a:
        assert property (PROT == RFO_PROT_A |=> !RX_CFG.pulse_rx)
        else $error("pulse reception chosen for type A");
    a_fifo_only:
        assert property (PT_CFG.fifo_only |->
            !(PT_CFG.auto_anticoll_en && PT_CFG.auto_poll_en))
        else $error("fifo only with both replies on");
endmodule

bind rfo_framing rfo_framing_chk i_chk (
    .CLK, .RST_N, .BVALID, .BREADY, .ARVALID, .ARREADY,
    .RVALID, .RREADY, .RDATA, .PROT, .COHERENT_RX,
    .REQ_WUP_SENT, .ANTICOLL_FRAME, .RX_CFG, .PT_CFG
);

/* File: verification/rfo_engine_model.sv */
`timescale 1ns/1ps

// Stands for the protocol engine that faces the field.
module rfo_engine_model
    import rfo_pkg::*;
(
    // Clock
    input  wire logic   clk,
    // Framing context
    output rfo_prot_t   prot,
    output logic        coherent_rx,
    output logic        req_wup_sent,
    output logic        anticoll_frame,
    output logic        passive_target,
    output rfo_smode_t  stream_mode,
    // Frame delay start
    output logic        fdt_start,
    output logic [11:0] fdt_nominal
);
    initial
    begin
        prot = RFO_PROT_B;
        stream_mode = RFO_SM_OFF;
        {coherent_rx, req_wup_sent, anticoll_frame, passive_target} = 4'h9;
        fdt_start = 1'b0;
        fdt_nominal = 12'h000;
    end

    task ctx(input rfo_prot_t p, input rfo_smode_t m, input logic [3:0] f);
        @(posedge clk);
        prot <= p;
        stream_mode <= m;
        {coherent_rx, req_wup_sent, anticoll_frame, passive_target} <= f;
    endtask

    task fire(input logic [11:0] n);
        @(posedge clk);
        fdt_nominal <= n;
        fdt_start <= 1'b1;
        @(posedge clk);
        fdt_start <= 1'b0;
    endtask
endmodule

/* File: verification/tb_rfo_framing.sv */
`timescale 1ns/1ps

module tb_rfo_framing
    import rfo_pkg::*;
();
    typedef struct {logic [7:0] idx, wd, rd; logic [1:0] rsp;} rfo_row_t;
    typedef struct {rfo_smode_t m; logic [7:0] wd; logic [12:0] c;} rfo_sm_t;

    logic        CLK = 1'b0;
    logic        RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, FDT_DONE;
    logic        SUBC_TICK, TX_TICK, REPORT_TICK, FDT_START, COHERENT_RX;
    logic        REQ_WUP_SENT, ANTICOLL_FRAME, PASSIVE_TARGET;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rd;
    logic [11:0] FDT_NOMINAL;
    logic [3:0]  WSTRB;
    logic [1:0]  BRESP, RRESP, rsp;
    rfo_prot_t   PROT;
    rfo_smode_t  STREAM_MODE;
    rfo_rx_cfg_t RX_CFG;
    rfo_pt_cfg_t PT_CFG;
    rfo_sm_cfg_t SM_CFG;
    int          n_fail = 0;
    int          n_checks = 0;
    int          n;
    int          nd[2];
    wire [2:0]   ticks = {REPORT_TICK, TX_TICK, SUBC_TICK};

    rfo_row_t rows[6] = '{'{8'h07, 8'hFF, 8'hF3, 2'h0},
        '{8'h08, 8'hFF, 8'hFD, 2'h0}, '{8'h09, 8'hFF, 8'h7F, 2'h0},
        '{8'h0A, 8'hFF, 8'hBF, 2'h0}, '{8'h0B, 8'hFF, 8'h0F, 2'h0},
        '{8'h05, 8'hFF, 8'h00, 2'h2}};
    rfo_sm_t sm[7] = '{'{RFO_SM_SUBC, 8'h31, {4'h5, 4'h4, 4'h6, 1'h0}},
        '{RFO_SM_SUBC, 8'h7B, {4'h3, 4'h8, 4'h4, 1'h0}},
        '{RFO_SM_BPSK, 8'h00, {4'h4, 4'h1, 4'h7, 1'h0}},
        '{RFO_SM_BPSK, 8'h08, {4'h4, 4'h2, 4'h7, 1'h0}},
        '{RFO_SM_SUBC, 8'h00, 13'h1}, '{RFO_SM_SUBC, 8'h14, 13'h1},
        '{RFO_SM_BPSK, 8'h20, 13'h1}};
    logic [3:0] fa[3] = '{4'h1, 4'h5, 4'h2};
    logic [1:0] ea[3] = '{2'h2, 2'h0, 2'h0};
    logic [7:0] pw[4] = '{8'h2D, 8'h21, 8'h04, 8'h00};
    logic [7:0] pe[4] = '{8'h21, 8'h2B, 8'h0D, 8'h0E};

    rfo_framing i_dut (.CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA,
        .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
        .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .PROT,
        .COHERENT_RX, .REQ_WUP_SENT, .ANTICOLL_FRAME, .PASSIVE_TARGET,
        .STREAM_MODE, .FDT_START, .FDT_NOMINAL, .RX_CFG, .PT_CFG, .SM_CFG,
        .FDT_DONE, .SUBC_TICK, .TX_TICK, .REPORT_TICK);

    rfo_engine_model i_eng (.clk(CLK), .prot(PROT),
        .coherent_rx(COHERENT_RX), .req_wup_sent(REQ_WUP_SENT),
        .anticoll_frame(ANTICOLL_FRAME), .passive_target(PASSIVE_TARGET),
        .stream_mode(STREAM_MODE), .fdt_start(FDT_START),
        .fdt_nominal(FDT_NOMINAL));

    always #50 CLK = ~CLK;

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // Each transfer starts on a fresh edge so no signal is driven twice.
    task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge CLK);
        AWADDR <= {22'h0, a, 2'h0};
        WDATA <= {24'h0, d};
        WSTRB <= s;
        {AWVALID, WVALID, BREADY} <= 3'h7;
        do
        begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        rsp = BRESP;
    endtask

    task rdr(input logic [7:0] a);
        @(posedge CLK);
        ARADDR <= {22'h0, a, 2'h0};
        {ARVALID, RREADY} <= 2'h3;
        do
        begin
            @(posedge CLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        rd = RDATA;
        rsp = RRESP;
    endtask

    task st;
        repeat (3) @(posedge CLK);
    endtask

    task gap(input int s, input int e);
        do @(posedge CLK); while (ticks[s] !== 1'b1);
        n = 0;
        do
        begin
            @(posedge CLK);
            n++;
        end while (ticks[s] !== 1'b1 && n < 999);
        chk(n, e);
    endtask

    task print_verdict;
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // The whole sequence needs under a thousand cycles.
    initial
    begin
        repeat (30000) @(posedge CLK);
        n_fail++;
        print_verdict;
    end

    initial
    begin
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h0;
        {AWADDR, WDATA, ARADDR} = 96'h0;
        WSTRB = 4'hF;
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        for (int i = 7; i < 11; i++)
        begin
            rdr(8'(i));
            chk(rd, 32'h0);
        end
        foreach (rows[i])
        begin
            wr(rows[i].idx, rows[i].wd, 4'hF);
            chk(rsp, rows[i].rsp);
            rdr(rows[i].idx);
            chk(rd, {24'h0, rows[i].rd});
            chk(rsp, rows[i].rsp);
        end
        wr(8'h0C, 8'h00, 4'hF);
        chk(rsp, 2'h2);
        wr(8'h07, 8'h00, 4'hE);
        rdr(8'h07);
        chk(rd, 32'hF3);
        wr(8'h0B, 8'h00, 4'hF);
        wr(8'h07, 8'h71, 4'hF);
        wr(8'h0A, 8'h06, 4'hF);
        st;
        chk(RX_CFG, {10'h200, 2'h3, 7'h40, 7'h68});
        i_eng.ctx(RFO_PROT_B, RFO_SM_OFF, 4'h1);
        st;
        chk(RX_CFG.accept_no_eof, 1'b0);
        i_eng.ctx(RFO_PROT_B, RFO_SM_OFF, 4'h9);
        wr(8'h07, 8'hC3, 4'hF);
        wr(8'h0A, 8'h88, 4'hF);
        st;
        chk(RX_CFG, {10'h000, 2'h0, 7'h60, 7'h10});
        wr(8'h0B, 8'h01, 4'hF);
        wr(8'h07, 8'h40, 4'hF);
        wr(8'h0A, 8'h04, 4'hF);
        st;
        chk(RX_CFG.tr1_min_fc, 10'h100);
        for (int i = 0; i < 3; i++)
        begin
            i_eng.ctx(RFO_PROT_A, RFO_SM_OFF, fa[i]);
            st;
            chk({RX_CFG.crc_check_en, RX_CFG.pulse_rx}, ea[i]);
        end
        i_eng.ctx(RFO_PROT_F, RFO_SM_OFF, 4'h0);
        st;
        chk(RX_CFG.pulse_rx, 1'b1);
        i_eng.ctx(RFO_PROT_A, RFO_SM_OFF, 4'h1);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h08, pw[i], 4'hF);
            st;
            chk(PT_CFG, pe[i]);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h08, i ? 8'h00 : 8'h20, 4'hF);
            st;
            i_eng.fire(12'h014);
            n = 0;
            do
            begin
                @(posedge CLK);
                n++;
            end while (FDT_DONE !== 1'b1 && n < 99);
            nd[i] = n;
        end
        chk(nd[1] - nd[0], 2);
        foreach (sm[i])
        begin
            i_eng.ctx(RFO_PROT_STREAM, sm[i].m, 4'h1);
            wr(8'h09, sm[i].wd, 4'hF);
            st;
            if (sm[i].c[0])
                chk(SM_CFG.cfg_error, 1'b1);
            else
                chk(SM_CFG, sm[i].c);
        end
        i_eng.ctx(RFO_PROT_STREAM, RFO_SM_SUBC, 4'h1);
        wr(8'h09, 8'h31, 4'hF);
        st;
        gap(0, 32);
        gap(2, 128);
        gap(1, 64);
        wr(8'h0A, 8'h00, 4'hF);
        st;
        rdr(8'h0C);
        chk(rd, 32'h06);
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        rdr(8'h07);
        chk(rd, 32'h0);
        print_verdict;
    end
endmodule
